/* File: rtl/irqrt_filter.sv */
/*
 Digital noise filter for one external interrupt input.
 Assumes the input is already synchronised to mclk and that step
 marks every cycle that counts toward stability.
*/
`timescale 1ns/1ns
`default_nettype none
module irqrt_filter (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Pin side
   input wire logic pin_sync,
   input wire logic step,
   input wire logic [7:0] width,
   // Qualified level
   output logic level
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic level_ff;
   logic nxt_level;

   // A change is accepted only after it stays put for width steps.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_level = level_ff;
      if (pin_sync == level_ff) begin
         nxt_cnt = 8'h00;
      end else if (step) begin
         if (cnt_ff + 8'h01 >= width) begin
            nxt_level = pin_sync;
            nxt_cnt = 8'h00;
         end else begin
            nxt_cnt = cnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_ff <= 8'h00;
         level_ff <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         level_ff <= nxt_level;
      end
   end

   assign level = level_ff;

   a_filter_reject_glitch: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (pin_sync != level_ff) && step && (cnt_ff + 8'h01 < width)
      |=> level_ff == $past(level_ff))
      else $error("filter passed a short pulse");
endmodule
`default_nettype wire

/* File: rtl/irqrt_pkg.sv */
/*
 Package for the interrupt return, trap and external input block.
 Assumes a 100 MHz mclk stands in for the fast clock, and that the
 slow-clock timebase arrives as a one-cycle tick from elsewhere.
*/
package irqrt_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] EXT_IRQ_CONTROL_ADDR = 8'h37;
   localparam logic [7:0] EXT_IRQ_CONTROL_RST = 8'h00;
   localparam int ONE_FILTER_SELECT_BIT = 7;
   localparam int ZERO_PIN_SELECT_BIT = 6;
   localparam int THREE_EDGE_BIT = 3;
   localparam int TWO_EDGE_BIT = 2;
   localparam int ONE_EDGE_BIT = 1;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hCE;
   // ----------------------------------------------------------------
   // Stack and opcode constants
   // ----------------------------------------------------------------
   localparam logic [15:0] STACK_FRAME_BYTES = 16'h0003;
   localparam logic [15:0] PC_LOW_OFFSET = 16'h0001;
   localparam logic [15:0] PC_HIGH_OFFSET = 16'h0002;
   localparam logic [7:0] SOFT_TRAP_OPCODE = 8'hFF;
   // ----------------------------------------------------------------
   // Filter widths in clock periods
   // ----------------------------------------------------------------
   localparam logic [7:0] REJECT_ZERO_FIVE = 8'h02;
   localparam logic [7:0] PASS_ZERO_FIVE = 8'h07;
   localparam logic [7:0] REJECT_TWO_THREE = 8'h07;
   localparam logic [7:0] PASS_TWO_THREE = 8'h19;
   localparam logic [7:0] REJECT_ONE_SHORT = 8'h0F;
   localparam logic [7:0] PASS_ONE_SHORT = 8'h31;
   localparam logic [7:0] REJECT_ONE_LONG = 8'h3F;
   localparam logic [7:0] PASS_ONE_LONG = 8'hC1;
   localparam logic [7:0] REJECT_SLOW = 8'h01;
   localparam logic [7:0] PASS_SLOW = 8'h03;
   localparam int NUM_EXT = 5;
endpackage

/* File: rtl/irqrt_top.sv */
/*
 Interrupt return, trap sources and external interrupt inputs.
 Assumes a CPU core drives the instruction strobes and consumes the
 stack, trap and latch outputs; pins are asynchronous to mclk.
*/
// Function
// - Either return reloads PC and status word; stack pointer up 3.
// - After acceptance, low PC byte at SP+1, high byte at SP+2.
// - Trap routine must change stacked address, else the trap fires again.
// - Pending requests sampled in last instruction cycle.
// - Soft trap instruction starts processing at once, highest priority.
// - Fetch from absent address in single-chip mode returns soft trap opcode.
// - Fetch from data RAM, buffer or special area raises fetch trap.
// - Watchdog control bit picks reset output or fetch trap interrupt.
// - Undefined opcode interrupts at once, even inside non-maskable service.
// - Fetch trap accepted at once, even inside non-maskable service.
// - Inputs need master enable and own flag; input zero also pin select.
// - With pin select 0, input zero falling edge never sets its latch.
// - Inputs zero and five reject under 2, pass 7 fast periods.
// - Inputs two and three reject under 7, pass 25 fast periods.
// - Input one rejects under 15 or 63, passes 49 or 193.
// - Slow modes: reject under one slow period, pass 3.5.
// - Clean edge sets latch within settling plus 6 slow periods.
// - Bit 7 picks input one width; change applies within 64 periods.
// - Bit 6 makes shared pin port or input zero; resets as port.
// - Bits 3..1 pick edge for inputs three..one; zero, five fall.
// - Master enable 0 blocks every maskable interrupt.
`timescale 1ns/1ns
`default_nettype none
module irqrt_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Core instruction status
   input wire logic instr_last_cycle,
   input wire logic return_maskable_instr,
   input wire logic return_nonmaskable_instr,
   input wire logic soft_trap_instr,
   input wire logic undefined_opcode,
   input wire logic [15:0] sp_in,
   input wire logic [7:0] stack_pc_low,
   input wire logic [7:0] stack_pc_high,
   input wire logic [7:0] stack_status,
   // Fetch checks
   input wire logic fetch_valid,
   input wire logic single_chip_mode,
   input wire logic fetch_addr_absent,
   input wire logic fetch_addr_data_area,
   input wire logic [7:0] fetch_data_in,
   input wire logic trap_to_reset,
   // Enables and modes
   input wire logic master_irq_enable,
   input wire logic enable_flag_four,
   input wire logic enable_flag_six,
   input wire logic enable_flag_eight,
   input wire logic enable_flag_twelve,
   input wire logic enable_flag_twentythree,
   input wire logic slow_mode,
   input wire logic slow_tick,
   input wire logic [4:0] latch_clear,
   // Pins, index 0..4 are inputs zero, one, two, three, five
   input wire logic [4:0] ext_pin,
   // Results to the core
   output logic [7:0] fetch_data_out,
   output logic [15:0] pc_restore,
   output logic [7:0] status_restore,
   output logic [15:0] sp_out,
   output logic [15:0] pc_low_addr,
   output logic [15:0] pc_high_addr,
   output logic fetch_trap_reset,
   output logic fetch_trap_irq,
   output logic software_irq,
   output logic undefined_opcode_irq,
   output logic [4:0] ext_latch,
   output logic ext_request,
   output logic ext_zero_pin_mode
);
   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (reg_wr && reg_addr == irqrt_pkg::EXT_IRQ_CONTROL_ADDR) begin
         nxt_ctrl = reg_wdata & irqrt_pkg::CONTROL_WRITE_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Return, trap and stack logic
   // ----------------------------------------------------------------
   logic [15:0] pc_ff, nxt_pc, sp_ff, nxt_sp, lo_ff, nxt_lo, hi_ff, nxt_hi;
   logic [7:0] st_ff, nxt_st, fd_ff, nxt_fd, rd_ff, nxt_rd;
   logic trst_ff, nxt_trst, tirq_ff, nxt_tirq, sw_ff, nxt_sw;
   logic ud_ff, nxt_ud, mode_ff, nxt_mode;
   logic is_return, trap_hit;

   assign is_return = return_maskable_instr | return_nonmaskable_instr;
   assign trap_hit = fetch_valid & fetch_addr_data_area;

   always_comb begin
      nxt_pc = pc_ff;
      nxt_st = st_ff;
      nxt_sp = sp_in;
      if (is_return) begin
         nxt_pc = {stack_pc_high, stack_pc_low};
         nxt_st = stack_status;
         nxt_sp = sp_in + irqrt_pkg::STACK_FRAME_BYTES;
      end
      nxt_lo = sp_in + irqrt_pkg::PC_LOW_OFFSET;
      nxt_hi = sp_in + irqrt_pkg::PC_HIGH_OFFSET;
      nxt_fd = fetch_data_in;
      if (single_chip_mode && fetch_addr_absent) begin
         nxt_fd = irqrt_pkg::SOFT_TRAP_OPCODE;
      end
      // Trap sources are taken at once, not at instruction end.
      nxt_trst = trap_hit & trap_to_reset;
      nxt_tirq = trap_hit & ~trap_to_reset;
      nxt_sw = soft_trap_instr;
      nxt_ud = undefined_opcode;
      nxt_mode = ctrl_ff[irqrt_pkg::ZERO_PIN_SELECT_BIT];
      nxt_rd = 8'h00;
      if (reg_addr == irqrt_pkg::EXT_IRQ_CONTROL_ADDR) begin
         nxt_rd = ctrl_ff;
      end
   end

   // ----------------------------------------------------------------
   // External inputs
   // ----------------------------------------------------------------
   logic [4:0] s1_ff, s2_ff, lvl, lvl_d_ff, act_edge, fall_edge;
   logic [4:0] lat_ff, nxt_lat, en;
   logic [4:0] edge_rise;
   logic [7:0] wid [5];
   logic step, req_ff, nxt_req;

   assign step = slow_mode ? slow_tick : 1'b1;
   assign edge_rise = {1'b0, ~ctrl_ff[irqrt_pkg::THREE_EDGE_BIT],
      ~ctrl_ff[irqrt_pkg::TWO_EDGE_BIT],
      ~ctrl_ff[irqrt_pkg::ONE_EDGE_BIT], 1'b0};

   // Widths sit at the pass bound, inside the reject/pass window.
   always_comb begin
      wid[0] = slow_mode ? irqrt_pkg::PASS_SLOW
         : irqrt_pkg::PASS_ZERO_FIVE;
      wid[4] = wid[0];
      wid[2] = slow_mode ? irqrt_pkg::PASS_SLOW
         : irqrt_pkg::PASS_TWO_THREE;
      wid[3] = wid[2];
      if (slow_mode) begin
         wid[1] = irqrt_pkg::PASS_SLOW;
      end else if (ctrl_ff[irqrt_pkg::ONE_FILTER_SELECT_BIT]) begin
         wid[1] = irqrt_pkg::PASS_ONE_SHORT;
      end else begin
         wid[1] = irqrt_pkg::PASS_ONE_LONG;
      end
   end

   genvar g;
   generate
      for (g = 0; g < irqrt_pkg::NUM_EXT; g++) begin : g_ext
         irqrt_filter u_filt (
            .mclk(mclk),
            .rst_b(rst_b),
            .pin_sync(s2_ff[g]),
            .step(step),
            .width(wid[g]),
            .level(lvl[g])
         );
         assign fall_edge[g] = lvl_d_ff[g] & ~lvl[g];
         assign act_edge[g] = edge_rise[g] ? (~lvl_d_ff[g] & lvl[g])
            : fall_edge[g];
      end
   endgenerate

   always_comb begin
      // A new edge wins over a clear in the same cycle.
      nxt_lat = (lat_ff & ~latch_clear) | act_edge;
      nxt_lat[0] = (lat_ff[0] & ~latch_clear[0])
         | (act_edge[0] & ctrl_ff[irqrt_pkg::ZERO_PIN_SELECT_BIT]);
      en = {enable_flag_twentythree, enable_flag_twelve,
         enable_flag_eight, enable_flag_six,
         enable_flag_four & ctrl_ff[irqrt_pkg::ZERO_PIN_SELECT_BIT]};
      nxt_req = req_ff;
      if (instr_last_cycle) begin
         nxt_req = master_irq_enable & |(lat_ff & en);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_ff <= irqrt_pkg::EXT_IRQ_CONTROL_RST;
         pc_ff <= 16'h0000;
         st_ff <= 8'h00;
         sp_ff <= 16'h0000;
         lo_ff <= 16'h0000;
         hi_ff <= 16'h0000;
         fd_ff <= 8'h00;
         rd_ff <= 8'h00;
         trst_ff <= 1'b0;
         tirq_ff <= 1'b0;
         sw_ff <= 1'b0;
         ud_ff <= 1'b0;
         mode_ff <= 1'b0;
         s1_ff <= 5'h1F;
         s2_ff <= 5'h1F;
         lvl_d_ff <= 5'h1F;
         lat_ff <= 5'h00;
         req_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         pc_ff <= nxt_pc;
         st_ff <= nxt_st;
         sp_ff <= nxt_sp;
         lo_ff <= nxt_lo;
         hi_ff <= nxt_hi;
         fd_ff <= nxt_fd;
         rd_ff <= nxt_rd;
         trst_ff <= nxt_trst;
         tirq_ff <= nxt_tirq;
         sw_ff <= nxt_sw;
         ud_ff <= nxt_ud;
         mode_ff <= nxt_mode;
         s1_ff <= ext_pin;
         s2_ff <= s1_ff;
         lvl_d_ff <= lvl;
         lat_ff <= nxt_lat;
         req_ff <= nxt_req;
      end
   end

   assign reg_rdata = rd_ff;
   assign fetch_data_out = fd_ff;
   assign pc_restore = pc_ff;
   assign status_restore = st_ff;
   assign sp_out = sp_ff;
   assign pc_low_addr = lo_ff;
   assign pc_high_addr = hi_ff;
   assign fetch_trap_reset = trst_ff;
   assign fetch_trap_irq = tirq_ff;
   assign software_irq = sw_ff;
   assign undefined_opcode_irq = ud_ff;
   assign ext_latch = lat_ff;
   assign ext_request = req_ff;
   assign ext_zero_pin_mode = mode_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_return;
      is_return;
   endsequence

   a_return_sp_up: assert property (s_return |=>
      sp_ff == $past(sp_in) + irqrt_pkg::STACK_FRAME_BYTES)
      else $error("return did not raise stack pointer by three");
   a_return_restore: assert property (s_return |=>
      pc_restore == $past({stack_pc_high, stack_pc_low})
      && status_restore == $past(stack_status))
      else $error("return did not restore pc and status");
   a_pc_byte_addr: assert property (1'b1 |=>
      lo_ff == $past(sp_in) + irqrt_pkg::PC_LOW_OFFSET
      && hi_ff == $past(sp_in) + irqrt_pkg::PC_HIGH_OFFSET)
      else $error("stacked byte addresses out of order");
   a_req_hold_idle: assert property (!instr_last_cycle |=>
      $stable(ext_request))
      else $error("request changed outside last cycle");
   a_soft_trap_now: assert property (
      soft_trap_instr |=> software_irq)
      else $error("soft trap not raised at once");
   a_absent_fetch_ff: assert property (
      single_chip_mode && fetch_addr_absent
      |=> fetch_data_out == irqrt_pkg::SOFT_TRAP_OPCODE)
      else $error("absent fetch not forced to soft trap");
   a_trap_route_sel: assert property (
      trap_hit |=> (fetch_trap_reset != fetch_trap_irq)
      && fetch_trap_reset == $past(trap_to_reset))
      else $error("fetch trap routed wrongly");
   a_undef_now: assert property (
      undefined_opcode |=> undefined_opcode_irq)
      else $error("undefined opcode not raised");
   a_zero_pin_gate: assert property (
      !ctrl_ff[irqrt_pkg::ZERO_PIN_SELECT_BIT] && !lat_ff[0] |=> !lat_ff[0])
      else $error("input zero latched while pin is a port");
   a_edge_sets_latch: assert property (
      act_edge[4:1] != 4'h0 |=>
      (ext_latch[4:1] & $past(act_edge[4:1])) == $past(act_edge[4:1]))
      else $error("active edge did not set its latch");
   a_master_block: assert property (
      instr_last_cycle && !master_irq_enable |=> !ext_request)
      else $error("request passed with master enable low");
endmodule
`default_nettype wire

/* File: test/irq_return_traps_ext_inputs_test.sv */
/*
 Self-checking bench for the return, trap and external input block.
 Assumes the pin model beside it and a free-running slow tick.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_return_traps_ext_inputs_test;
   localparam int SLOW = 8;
   // Filter settling plus six slow periods and pipeline margin.
   localparam int LATCH_WAIT = 200 + 6 * SLOW;
   logic mclk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, instr_last_cycle = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [1:0] ret = 2'h0;
   logic soft_trap_instr = 1'h0, undefined_opcode = 1'h0, fetch_valid = 1'h0;
   logic single_chip_mode = 1'h0, fetch_addr_absent = 1'h0;
   logic fetch_addr_data_area = 1'h0, trap_to_reset = 1'h0;
   logic [15:0] sp_in = 16'hFFFE;
   logic [23:0] stk = 24'h1234A5;
   logic master_irq_enable = 1'h0, slow_mode = 1'h0, slow_tick = 1'h0;
   logic [4:0] en = 5'h00, latch_clear = 5'h00, ext_pin, ext_latch;
   logic [2:0] tick_cnt = 3'h0, pulse_sel = 3'h0;
   logic [7:0] pulse_len = 8'h01, reg_rdata, fetch_data_out, status_restore;
   logic pulse_go = 1'h0, pulse_busy, ext_request, ext_zero_pin_mode;
   logic [15:0] pc_restore, sp_out, pc_low_addr, pc_high_addr;
   logic fetch_trap_reset, fetch_trap_irq, software_irq, undefined_opcode_irq;
   int num_errors = 0, total_checks = 0;
   // Pulse cases: control, input, low cycles, latched at pulse end,
   // latched after settling, slow mode.
   logic [21:0] pulse_tab [18] = '{
      {8'h00, 3'h0, 8'h14, 1'h0, 1'h0, 1'h0},
      {8'h40, 3'h0, 8'h01, 1'h0, 1'h0, 1'h0},
      {8'h40, 3'h0, 8'h07, 1'h0, 1'h1, 1'h0},
      {8'h40, 3'h0, 8'h14, 1'h1, 1'h1, 1'h0},
      {8'h00, 3'h4, 8'h01, 1'h0, 1'h0, 1'h0},
      {8'h00, 3'h4, 8'h07, 1'h0, 1'h1, 1'h0},
      {8'h00, 3'h2, 8'h06, 1'h0, 1'h0, 1'h0},
      {8'h00, 3'h2, 8'h19, 1'h0, 1'h1, 1'h0},
      {8'h04, 3'h2, 8'h28, 1'h1, 1'h1, 1'h0},
      {8'h00, 3'h3, 8'h28, 1'h0, 1'h1, 1'h0},
      {8'h08, 3'h3, 8'h28, 1'h1, 1'h1, 1'h0},
      {8'h00, 3'h1, 8'h3E, 1'h0, 1'h0, 1'h0},
      {8'h00, 3'h1, 8'hC1, 1'h0, 1'h1, 1'h0},
      {8'h80, 3'h1, 8'h0E, 1'h0, 1'h0, 1'h0},
      {8'h80, 3'h1, 8'h31, 1'h0, 1'h1, 1'h0},
      {8'h82, 3'h1, 8'h50, 1'h1, 1'h1, 1'h0},
      {8'h40, 3'h0, 8'h04, 1'h0, 1'h0, 1'h1},
      {8'h40, 3'h0, 8'h1C, 1'h0, 1'h1, 1'h1}};
   // Trap cases: strobes, flags seen, fetched byte.
   logic [18:0] trap_tab [6] = '{
      {7'h41, 4'h8, 8'h5A},
      {7'h21, 4'h4, 8'h5A},
      {7'h19, 4'h0, 8'hFF},
      {7'h09, 4'h0, 8'h5A},
      {7'h05, 4'h2, 8'h5A},
      {7'h07, 4'h1, 8'h5A}};
   irqrt_top i_dut (
      .mclk, .rst_b, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .instr_last_cycle, .return_maskable_instr(ret[0]),
      .return_nonmaskable_instr(ret[1]), .soft_trap_instr,
      .undefined_opcode, .sp_in, .stack_pc_low(stk[15:8]),
      .stack_pc_high(stk[23:16]), .stack_status(stk[7:0]), .fetch_valid,
      .single_chip_mode, .fetch_addr_absent, .fetch_addr_data_area,
      .fetch_data_in(8'h5A), .trap_to_reset, .master_irq_enable,
      .enable_flag_four(en[0]), .enable_flag_six(en[1]),
      .enable_flag_eight(en[2]), .enable_flag_twelve(en[3]),
      .enable_flag_twentythree(en[4]), .slow_mode, .slow_tick,
      .latch_clear, .ext_pin, .fetch_data_out, .pc_restore,
      .status_restore, .sp_out, .pc_low_addr, .pc_high_addr,
      .fetch_trap_reset, .fetch_trap_irq, .software_irq,
      .undefined_opcode_irq, .ext_latch, .ext_request, .ext_zero_pin_mode);
   irqrt_pin_model i_pins (
      .mclk, .pulse_go, .pulse_sel, .pulse_len, .ext_pin, .pulse_busy);
   always #5 mclk = ~mclk;
   always @(negedge mclk) begin
      tick_cnt <= tick_cnt + 3'h1;
      slow_tick <= (tick_cnt == 3'h7);
   end
   // ----------------------------------------------------------------
   // Access and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge mclk);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(negedge mclk);
      reg_addr = a;
      repeat (2) @(negedge mclk);
      chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   task automatic pulse(input logic [2:0] idx, input logic [7:0] len,
                        input logic mid, fin);
      int i;
      @(negedge mclk);
      latch_clear = 5'h1F;
      @(negedge mclk);
      latch_clear = 5'h00;
      pulse_sel = idx;
      pulse_len = len;
      pulse_go = 1'h1;
      @(negedge mclk);
      pulse_go = 1'h0;
      for (i = 0; i < 300 && pulse_busy; i++) @(negedge mclk);
      if (!slow_mode)
         chk("latch at end", {15'h0, mid},
            {15'h0, ext_latch[idx]});
      repeat (LATCH_WAIT) @(negedge mclk);
      chk("ext_latch", {11'h0, {4'h0, fin} << idx},
         {11'h0, ext_latch});
      // Request with one flag, no master, other flags, no final cycle.
      for (i = 0; i < 4; i++) begin
         master_irq_enable = (i != 1);
         en = (i == 1) ? 5'h1F : (i == 2) ? ~(5'h01 << idx) : 5'h01 << idx;
         instr_last_cycle = (i != 3);
         @(negedge mclk);
         instr_last_cycle = 1'h0;
         repeat (2) @(negedge mclk);
         chk("ext_request", {15'h0, fin && i == 0},
            {15'h0, ext_request});
      end
      master_irq_enable = 1'h0;
      en = 5'h00;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (30000) @(posedge mclk);
      num_errors++;
      $display("watchdog expired");
      conclude();
   end
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'h1;
      rd(8'h37, 8'h00);
      chk("pin mode", 16'h0000, {15'h0, ext_zero_pin_mode});
      wr(8'h37, 8'hFF);
      rd(8'h37, 8'hCE);
      chk("pin mode", 16'h0001, {15'h0, ext_zero_pin_mode});
      wr(8'h38, 8'h00);
      rd(8'h37, 8'hCE);
      rd(8'h38, 8'h00);
      // A second reset must bring the shared pin back to a port.
      @(negedge mclk);
      rst_b = 1'h0;
      repeat (3) @(negedge mclk);
      rst_b = 1'h1;
      rd(8'h37, 8'h00);
      chk("pin mode", 16'h0000, {15'h0, ext_zero_pin_mode});
      $display("registers done");
      for (int k = 0; k < 2; k++) begin
         @(negedge mclk);
         stk = (k == 0) ? 24'h1234A5 : 24'h56785A;
         ret = 2'h1 << k;
         @(negedge mclk);
         ret = 2'h0;
         chk("pc_restore", (k == 0) ? 16'h1234 : 16'h5678,
            pc_restore);
         chk("status_restore", (k == 0) ? 16'h00A5 : 16'h005A,
            {8'h00, status_restore});
         chk("sp_out", 16'h0001, sp_out);
         chk("pc_low_addr", 16'hFFFF, pc_low_addr);
         chk("pc_high_addr", 16'h0000, pc_high_addr);
         @(negedge mclk);
         chk("sp_out idle", 16'hFFFE, sp_out);
      end
      // A trap routine that leaves by jump raises the stack pointer thrice.
      repeat (3) begin
         @(negedge mclk);
         sp_in = sp_in + 16'h0001;
      end
      @(negedge mclk);
      chk("sp_out jump exit", 16'h0001, sp_out);
      $display("returns done");
      foreach (trap_tab[k]) begin
         @(negedge mclk);
         {soft_trap_instr, undefined_opcode, single_chip_mode,
          fetch_addr_absent, fetch_addr_data_area, trap_to_reset,
          fetch_valid} = trap_tab[k][18:12];
         @(negedge mclk);
         {soft_trap_instr, undefined_opcode, fetch_valid} = 3'h0;
         chk("trap flags", {12'h0, trap_tab[k][11:8]},
            {12'h0, software_irq, undefined_opcode_irq, fetch_trap_irq,
            fetch_trap_reset});
         chk("fetch_data_out", {8'h00, trap_tab[k][7:0]},
            {8'h00, fetch_data_out});
      end
      $display("traps done");
      foreach (pulse_tab[k]) begin
         slow_mode = pulse_tab[k][0];
         wr(8'h37, pulse_tab[k][21:14]);
         pulse(pulse_tab[k][13:11], pulse_tab[k][10:3], pulse_tab[k][2],
            pulse_tab[k][1]);
      end
      $display("pins done");
      conclude();
   end
endmodule
`default_nettype wire

/* File: test/irqrt_pin_model.sv */
/*
 Outside circuitry on the five interrupt pins.
 Assumes pulled-up pins and one low pulse requested at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module irqrt_pin_model (
   // Clock
   input wire logic mclk,
   // Pulse request
   input wire logic pulse_go,
   input wire logic [2:0] pulse_sel,
   input wire logic [7:0] pulse_len,
   // Pins
   output logic [4:0] ext_pin,
   output logic pulse_busy
);
   logic [7:0] cnt = 8'h00;
   logic [4:0] pin_lvl = 5'h1F;
   assign ext_pin = pin_lvl;
   assign pulse_busy = (cnt != 8'h00);
   // Holds one pin low for pulse_len cycles, then the pull-up returns it.
   always @(posedge mclk) begin
      if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
         if (cnt == 8'h01) begin
            pin_lvl <= 5'h1F;
         end
      end else if (pulse_go) begin
         cnt <= pulse_len;
         pin_lvl <= ~(5'h01 << pulse_sel);
      end
   end
endmodule
`default_nettype wire
